// file: src/iso_split_pkg.sv
package iso_split_pkg;

  // Positions inside descriptor quad word 0 (DW1:DW0)
  localparam int HUB_ADDR_LSB = 57;
  localparam int HUB_ADDR_W = 7;
  localparam int PORT_NUM_LSB = 50;
  localparam int PORT_NUM_W = 7;
  localparam int SPLIT_SEL_BIT = 46;
  localparam int TRANSFER_TYPE_LSB = 44;
  localparam int TRANSFER_TYPE_W = 2;
  localparam int TOKEN_LSB = 42;
  localparam int TOKEN_W = 2;
  localparam int DEV_ADDR_LSB = 35;
  localparam int DEV_ADDR_W = 7;
  localparam int EP_HI_LSB = 32;
  localparam int EP_HI_W = 3;
  localparam int EP_LO_BIT = 31;
  localparam int BPS_LSB = 18;
  localparam int BPS_W = 11;
  localparam int TOTAL_LSB = 3;
  localparam int TOTAL_W = 15;
  localparam int VALID_BIT = 0;

  // Positions inside descriptor quad word 1 (DW3:DW2)
  localparam int FRAME_SEL_LSB = 3;
  localparam int FRAME_SEL_W = 5;
  localparam int BUF_ADDR_LSB = 8;
  localparam int BUF_ADDR_W = 16;

  localparam int UFRAME_W = 3;
  localparam int UFRAME_MASK_W = 8;

  localparam logic [1:0] TOKEN_CODE_OUT = 2'h0;
  localparam logic [1:0] TOKEN_CODE_IN = 2'h1;
  localparam logic [1:0] TRANSFER_TYPE_ISO = 2'h1;

  typedef enum logic [1:0] {
    TOKEN_OUT = 2'b00,
    TOKEN_IN = 2'b01
  } token_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_USOF = 2'b01,
    ST_WAIT_DONE = 2'b10
  } sched_state_t;

  typedef struct packed {
    logic [HUB_ADDR_W-1:0] translator_hub_addr;
    logic [PORT_NUM_W-1:0] translator_port_num;
    logic split_sel;
    token_t token;
    logic [DEV_ADDR_W-1:0] dev_addr;
    logic [EP_HI_W:0] endpoint_num;
    logic [BPS_W-1:0] xfer_len;
    logic [BUF_ADDR_W-1:0] buffer_start_addr;
  } split_token_t;

  typedef struct packed {
    sched_state_t st;
    split_token_t tok;
    logic [BPS_W-1:0] bytes_per_start_split;
    logic [TOTAL_W-1:0] total_byte_count;
    logic [FRAME_SEL_W-1:0] frame_sel;
    logic [UFRAME_MASK_W-1:0] start_split_uframe_mask;
    logic [UFRAME_W-1:0] active_uframe;
    logic valid;
    logic split_req;
    logic hs_req;
    logic valid_clear;
    logic desc_reject;
  } ctl_t;

  localparam ctl_t CTL_RESET = '0;

endpackage

// file: src/bit_field.sv
`timescale 1ns/1ps
module bit_field #(
  parameter int LSB = 0,
  parameter int W = 1
) (
  input wire logic [63:0] word_i,
  output logic [W-1:0] field_o
);
  assign field_o = word_i[LSB +: W];
endmodule

// file: src/split_chunk.sv
`timescale 1ns/1ps
module split_chunk #(
  parameter int REM_W = 15,
  parameter int LEN_W = 11
) (
  input wire logic [REM_W-1:0] remaining_i,
  input wire logic [LEN_W-1:0] limit_i,
  output logic [LEN_W-1:0] chunk_o
);
  logic [REM_W-1:0] limit_ext;
  assign limit_ext = {{(REM_W-LEN_W){1'b0}}, limit_i};
  // Never more than the translator accepts per start split
  assign chunk_o = (remaining_i < limit_ext) ? remaining_i[LEN_W-1:0] : limit_i;
endmodule

// file: src/iso_split_descriptor_fields.sv
`timescale 1ns/1ps
module iso_split_descriptor_fields (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic desc_load_i,
  input wire logic [63:0] desc_qw0_i,
  input wire logic [63:0] desc_qw1_i,
  input wire logic [iso_split_pkg::UFRAME_MASK_W-1:0] start_split_uframe_mask_i,
  input wire logic usof_i,
  input wire logic [iso_split_pkg::FRAME_SEL_W-1:0] bus_frame_num_i,
  input wire logic [iso_split_pkg::UFRAME_W-1:0] bus_uframe_i,
  input wire logic xfer_done_i,
  input wire logic [iso_split_pkg::BPS_W-1:0] bytes_moved_i,
  input wire logic fatal_err_i,
  output iso_split_pkg::split_token_t token_o,
  output logic split_req_o,
  output logic hs_req_o,
  output logic desc_valid_o,
  output logic valid_clear_o,
  output logic desc_reject_o,
  output logic [iso_split_pkg::UFRAME_MASK_W-1:0] start_split_uframe_mask_o,
  output logic [iso_split_pkg::TOTAL_W-1:0] total_byte_count_o
);
  import iso_split_pkg::*;

  ctl_t q;
  ctl_t d;

  logic [HUB_ADDR_W-1:0] f_hub;
  logic [PORT_NUM_W-1:0] f_port;
  logic [TRANSFER_TYPE_W-1:0] f_type;
  logic [TOKEN_W-1:0] f_token;
  logic [DEV_ADDR_W-1:0] f_dev;
  logic [EP_HI_W-1:0] f_ep_hi;
  logic [BPS_W-1:0] f_bps;
  logic [TOTAL_W-1:0] f_total;
  logic [FRAME_SEL_W-1:0] f_frame;
  logic [BUF_ADDR_W-1:0] f_buf;
  logic [BPS_W-1:0] chunk;

  bit_field #(.LSB(HUB_ADDR_LSB), .W(HUB_ADDR_W)) u_hub (
    .word_i(desc_qw0_i),
    .field_o(f_hub)
  );
  bit_field #(.LSB(PORT_NUM_LSB), .W(PORT_NUM_W)) u_port (
    .word_i(desc_qw0_i),
    .field_o(f_port)
  );
  bit_field #(.LSB(TRANSFER_TYPE_LSB), .W(TRANSFER_TYPE_W)) u_type (
    .word_i(desc_qw0_i),
    .field_o(f_type)
  );
  bit_field #(.LSB(TOKEN_LSB), .W(TOKEN_W)) u_token (
    .word_i(desc_qw0_i),
    .field_o(f_token)
  );
  bit_field #(.LSB(DEV_ADDR_LSB), .W(DEV_ADDR_W)) u_dev (
    .word_i(desc_qw0_i),
    .field_o(f_dev)
  );
  bit_field #(.LSB(EP_HI_LSB), .W(EP_HI_W)) u_ep_hi (
    .word_i(desc_qw0_i),
    .field_o(f_ep_hi)
  );
  bit_field #(.LSB(BPS_LSB), .W(BPS_W)) u_bps (
    .word_i(desc_qw0_i),
    .field_o(f_bps)
  );
  bit_field #(.LSB(TOTAL_LSB), .W(TOTAL_W)) u_total (
    .word_i(desc_qw0_i),
    .field_o(f_total)
  );
  bit_field #(.LSB(FRAME_SEL_LSB), .W(FRAME_SEL_W)) u_frame (
    .word_i(desc_qw1_i),
    .field_o(f_frame)
  );
  bit_field #(.LSB(BUF_ADDR_LSB), .W(BUF_ADDR_W)) u_buf (
    .word_i(desc_qw1_i),
    .field_o(f_buf)
  );

  split_chunk #(.REM_W(TOTAL_W), .LEN_W(BPS_W)) u_chunk (
    .remaining_i(q.total_byte_count),
    .limit_i(q.bytes_per_start_split),
    .chunk_o(chunk)
  );

  logic token_ok;
  logic usof_hit;
  logic [TOTAL_W-1:0] moved_ext;
  logic [TOTAL_W-1:0] rem_next;
  logic [UFRAME_MASK_W-1:0] mask_next;
  logic [BUF_ADDR_W-1:0] moved_addr;

  // Codes above IN are not defined for this format
  assign token_ok = (f_token == TOKEN_CODE_OUT) || (f_token == TOKEN_CODE_IN);
  // Software owns the type field; a non-isochronous type is taken as a bad descriptor
  // since this format cannot carry it
  logic type_ok;
  assign type_ok = (f_type == TRANSFER_TYPE_ISO);

  // Frame match on bits 7..3 only; the microframe comes from the mask
  assign usof_hit = usof_i && (bus_frame_num_i == q.frame_sel)
                    && q.start_split_uframe_mask[bus_uframe_i];
  assign moved_ext = {{(TOTAL_W-BPS_W){1'b0}}, bytes_moved_i};
  assign moved_addr = {{(BUF_ADDR_W-BPS_W){1'b0}}, bytes_moved_i};
  // An overlong report is clamped so the count never wraps
  assign rem_next = (moved_ext >= q.total_byte_count) ? '0
                  : q.total_byte_count - moved_ext;

  always_comb begin
    mask_next = q.start_split_uframe_mask;
    mask_next[q.active_uframe] = 1'b0;
  end

  always_comb begin
    d = q;
    d.split_req = 1'b0;
    d.hs_req = 1'b0;
    d.valid_clear = 1'b0;
    d.desc_reject = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (desc_load_i && desc_qw0_i[VALID_BIT]) begin
          d.tok.translator_hub_addr = f_hub;
          d.tok.translator_port_num = f_port;
          d.tok.split_sel = desc_qw0_i[SPLIT_SEL_BIT];
          d.tok.token = token_t'(f_token);
          d.tok.dev_addr = f_dev;
          d.tok.endpoint_num = {f_ep_hi, desc_qw0_i[EP_LO_BIT]};
          d.tok.buffer_start_addr = f_buf;
          d.tok.xfer_len = '0;
          d.bytes_per_start_split = f_bps;
          d.total_byte_count = f_total;
          d.frame_sel = f_frame;
          d.start_split_uframe_mask = start_split_uframe_mask_i;
          d.active_uframe = '0;
          if (!token_ok || !type_ok) begin
            // Bad descriptor: hand it straight back as finished
            d.desc_reject = 1'b1;
            d.valid_clear = 1'b1;
            d.valid = 1'b0;
          end else if ((f_total == '0) || (start_split_uframe_mask_i == '0)) begin
            // Nothing to move or nowhere to move it
            d.valid_clear = 1'b1;
            d.valid = 1'b0;
          end else begin
            d.valid = 1'b1;
            d.st = ST_WAIT_USOF;
          end
        end
      end
      ST_WAIT_USOF: begin
        if (fatal_err_i) begin
          d.valid = 1'b0;
          d.valid_clear = 1'b1;
          d.st = ST_IDLE;
        end else if (usof_hit) begin
          d.active_uframe = bus_uframe_i;
          d.tok.xfer_len = chunk;
          // Split through the translator or plain high-speed transaction
          d.split_req = q.tok.split_sel;
          d.hs_req = !q.tok.split_sel;
          d.st = ST_WAIT_DONE;
        end
      end
      ST_WAIT_DONE: begin
        if (fatal_err_i) begin
          d.valid = 1'b0;
          d.valid_clear = 1'b1;
          d.st = ST_IDLE;
        end else if (xfer_done_i) begin
          d.total_byte_count = rem_next;
          // Payload lives in the internal buffer, so the address steps with the bytes
          d.tok.buffer_start_addr = q.tok.buffer_start_addr + moved_addr;
          d.start_split_uframe_mask = mask_next;
          if ((rem_next == '0) || (mask_next == '0)) begin
            d.valid = 1'b0;
            d.valid_clear = 1'b1;
            d.st = ST_IDLE;
          end else begin
            d.st = ST_WAIT_USOF;
          end
        end
      end
      default: begin
        d = CTL_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  assign token_o = q.tok;
  assign split_req_o = q.split_req;
  assign hs_req_o = q.hs_req;
  assign desc_valid_o = q.valid;
  assign valid_clear_o = q.valid_clear;
  assign desc_reject_o = q.desc_reject;
  assign start_split_uframe_mask_o = q.start_split_uframe_mask;
  assign total_byte_count_o = q.total_byte_count;

endmodule

// file: sim/iso_split_checker.sv
`timescale 1ns/1ps
module iso_split_checker
  import iso_split_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic desc_load_i,
  input wire logic [63:0] desc_qw0_i,
  input wire logic [63:0] desc_qw1_i,
  input wire logic usof_i,
  input wire logic [FRAME_SEL_W-1:0] bus_frame_num_i,
  input wire logic xfer_done_i,
  input wire logic [BPS_W-1:0] bytes_moved_i,
  input wire logic fatal_err_i,
  input wire split_token_t token_o,
  input wire logic split_req_o,
  input wire logic hs_req_o,
  input wire logic desc_valid_o,
  input wire logic valid_clear_o,
  input wire logic desc_reject_o,
  input wire logic [TOTAL_W-1:0] total_byte_count_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Legal iso load while idle; a reject loads the fields too but is left out here
  sequence ld_s;
    desc_load_i && desc_qw0_i[0] && !desc_valid_o && !valid_clear_o &&
      desc_qw0_i[45:44] == 2'h1 && !desc_qw0_i[43];
  endsequence
  load_answer_a: assert property (ld_s |=> desc_valid_o || valid_clear_o)
    else $error("load gave no answer");
  fields_load_a: assert property (ld_s |=> token_o[54:27] ==
    $past({desc_qw0_i[63:50], desc_qw0_i[46], desc_qw0_i[43:31]})) else $error("bad fields");
  buf_load_a: assert property (ld_s |=> token_o.buffer_start_addr == $past(desc_qw1_i[23:8]))
    else $error("bad buffer start");
  req_kind_a: assert property (split_req_o || hs_req_o |->
    token_o.split_sel == split_req_o && !(split_req_o && hs_req_o)) else $error("bad kind");
  req_len_a: assert property (split_req_o || hs_req_o |->
    (token_o.xfer_len <= total_byte_count_o) ##1 !(split_req_o || hs_req_o))
    else $error("bad request length");
  frame_sel_a: assert property (usof_i && bus_frame_num_i != desc_qw1_i[7:3] |=>
    !split_req_o && !hs_req_o) else $error("request in wrong frame");
  fatal_end_a: assert property (desc_valid_o && fatal_err_i |=> valid_clear_o && !desc_valid_o)
    else $error("fatal did not end");
  clear_drop_a: assert property (valid_clear_o |-> !desc_valid_o)
    else $error("clear while valid");
  total_left_a: assert property (desc_valid_o && xfer_done_i && !fatal_err_i |=>
    total_byte_count_o == ($past(total_byte_count_o) > $past(bytes_moved_i) ?
    $past(total_byte_count_o) - $past(bytes_moved_i) : 15'h0000)) else $error("bad total");
  buf_step_a: assert property (desc_valid_o && xfer_done_i && !fatal_err_i |=>
    token_o.buffer_start_addr == $past(token_o.buffer_start_addr) + $past(bytes_moved_i))
    else $error("bad buffer step");
  cover property (split_req_o);
  cover property (hs_req_o);
  cover property (desc_reject_o);
  cover property (desc_valid_o && fatal_err_i);
endmodule
bind iso_split_descriptor_fields iso_split_checker chk_u (.*);

// file: sim/tt_partner_model.sv
`timescale 1ns/1ps
module tt_partner_model
  import iso_split_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic req_i,
  input wire logic [BPS_W-1:0] len_i,
  input wire logic [3:0] lag_i,
  output logic done_o,
  output logic [BPS_W-1:0] moved_o
);
  int wait_n = -1;
  logic [BPS_W-1:0] held = '0;
  initial begin
    done_o = 1'b0;
    moved_o = '1;
  end
  always @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    // Idle count toggles so a stale value is never read as valid
    moved_o <= ~moved_o;
    if (req_i) begin
      wait_n = lag_i;
      held = len_i;
    end else if (wait_n > 0) begin
      wait_n--;
    end
    if (wait_n == 0) begin
      done_o <= 1'b1;
      moved_o <= held;
      wait_n = -1;
    end
  end
endmodule

// file: sim/iso_split_descriptor_fields_tb.sv
`timescale 1ns/1ps
module iso_split_descriptor_fields_tb;
  import iso_split_pkg::*;
  logic clk_sys_i = 0, reset_n_i = 0, desc_load_i = 0, usof_i = 0, fatal_err_i = 0;
  logic [63:0] desc_qw0_i = '0, desc_qw1_i = '0;
  logic [UFRAME_MASK_W-1:0] start_split_uframe_mask_i = '0, start_split_uframe_mask_o;
  logic [FRAME_SEL_W-1:0] bus_frame_num_i = '0;
  logic [UFRAME_W-1:0] bus_uframe_i = '0;
  logic xfer_done_i, split_req_o, hs_req_o, desc_valid_o, valid_clear_o, desc_reject_o;
  logic [BPS_W-1:0] bytes_moved_i;
  split_token_t token_o;
  logic [TOTAL_W-1:0] total_byte_count_o;
  logic [3:0] lag = '0;
  int miscompares = 0, compares = 0;
  // Set by a run that timed out, so later runs skip and the report comes once
  bit hung = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  iso_split_descriptor_fields dut_u (.*);
  tt_partner_model pm_u (.clk_sys_i(clk_sys_i), .req_i(split_req_o | hs_req_o),
    .len_i(token_o.xfer_len), .lag_i(lag), .done_o(xfer_done_i), .moved_o(bytes_moved_i));
  task automatic tick;
    @(negedge clk_sys_i);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic run(input logic sp, input logic [1:0] tk, input int total, input int bps,
                     input logic [7:0] mask, input int fatal_at);
    logic [63:0] q0;
    logic [7:0] m;
    int rem, addr, len, n;
    if (hung) return;
    q0 = {$urandom(), $urandom()};
    q0[46] = sp;
    q0[45:44] = TRANSFER_TYPE_ISO;
    q0[43:42] = tk;
    q0[28:18] = bps[10:0];
    q0[17:3] = total[14:0];
    q0[0] = 1'b1;
    desc_qw0_i = q0;
    desc_qw1_i = {$urandom(), $urandom()};
    start_split_uframe_mask_i = mask;
    rem = total;
    addr = desc_qw1_i[23:8];
    m = mask;
    desc_load_i = 1'b1;
    tick;
    desc_load_i = 1'b0;
    chk(desc_reject_o, tk[1]);
    chk(desc_valid_o, !tk[1]);
    chk(valid_clear_o, tk[1]);
    if (tk[1]) return;
    chk(token_o[54:27], {q0[63:50], q0[46], q0[43:31]});
    for (int u = 0; u < 8; u++) begin
      for (int hit = 0; hit < 2; hit++) begin
        tick;
        bus_uframe_i = u[2:0];
        bus_frame_num_i = desc_qw1_i[7:3] + 5'(1 - hit);
        if (hit == 1 && u == fatal_at) begin
          fatal_err_i = 1'b1;
          tick;
          fatal_err_i = 1'b0;
          chk({valid_clear_o, desc_valid_o}, 2'b10);
          return;
        end
        lag = 4'($urandom_range(0, 5));
        usof_i = 1'b1;
        tick;
        usof_i = 1'b0;
        chk(split_req_o, hit && m[u] && sp);
        chk(hs_req_o, hit && m[u] && !sp);
        if (hit == 1 && m[u]) begin
          len = rem < bps ? rem : bps;
          chk(token_o.xfer_len, len);
          chk(token_o.buffer_start_addr, addr);
          for (n = 0; n < 40 && xfer_done_i !== 1'b1; n++) tick;
          if (n == 40) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            hung = 1'b1;
            return;
          end
          tick;
          rem -= len;
          addr = (addr + len) & 32'h0000_ffff;
          m[u] = 1'b0;
          chk(total_byte_count_o, rem);
          chk(start_split_uframe_mask_o, m);
          chk(valid_clear_o, rem == 0 || m == 0);
          if (rem == 0 || m == 0) return;
        end
      end
    end
  endtask
  initial begin
    void'($urandom(32'hcc2a_4d57));
    repeat (20) tick;
    reset_n_i = 1'b1;
    desc_load_i = 1'b1;
    tick;
    desc_load_i = 1'b0;
    tick;
    chk({desc_valid_o, valid_clear_o}, 2'b00);
    run(1'b1, TOKEN_CODE_OUT, 376, 188, 8'h0f, 9);
    run(1'b1, TOKEN_CODE_IN, 200, 192, 8'h05, 9);
    run(1'b0, TOKEN_CODE_OUT, 1023, 188, 8'h81, 9);
    run(1'b1, TOKEN_CODE_IN, 400, 192, 8'h0e, 2);
    run(1'b0, 2'h2, 10, 10, 8'h01, 9);
    tally_and_finish;
  end
endmodule
